// >>> kbd_ctrl_host_port_tb.sv
// Self-checking bench for the keyboard controller host port
`timescale 1ns/1ps
`default_nettype none
module kbd_ctrl_host_port_tb;
    import khp_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, ctrlIbfIntEn = 1'b0, cd;
    logic [7:0]  ctrlWrData = '0, d;
    logic [10:0] cp = '0, romAddr = '0;
    logic [3:0]  ext = 4'hF, pv;
    logic [4:0]  ud = '0;
    logic [31:0] seed = 32'd23, v;
    int          failures = 0, checks = 0, wakes = 0;
    wire  [15:0] hostAddr;
    wire  [7:0]  hostDataIn, hostDataOut, ctrlRdData, ctrlStatus, ctrlPortState, romRdData;
    wire  [7:0]  ramRdData, ctrlPortData = ctrlWrData, romWrData = ctrlWrData;
    wire  [7:0]  ramWrData = ctrlWrData, ramAddr = romAddr[7:0];
    wire         hostRead_n, hostWrite_n, hostDataOe, ibfIrqReq, timerIrqReq, coreRunning;
    wire         oscEnable, wakeCall, kbdIrqOut, auxIrqOut, addrLine20Gate, kbdClockLineOut;
    wire         kbdDataLineOut, mouseClockLineOut, mouseDataLineOut, kbdClockSense;
    wire         kbdDataSense, mouseClockSense, mouseDataSense, kbdClockLineOe, kbdDataLineOe;
    wire         mouseClockLineOe, mouseDataLineOe, ctrlDataWr, ctrlDataRd, ctrlStatusWr;
    wire         ctrlPortWr, ctrlEnFlags, ctrlHalt, ctrlStop, timerOverflow, timerIrqAck;
    wire         romWr, ramWr;
    wire  [3:0]  oe = {kbdClockLineOe, kbdDataLineOe, mouseClockLineOe, mouseDataLineOe};
    wire  [3:0]  sn = {kbdClockSense, kbdDataSense, mouseClockSense, mouseDataSense};
    // Pull-ups hold each line high unless either end pulls it low
    wire  [3:0]  lin = ~oe & ext;
    wire         kbdClockLineIn = lin[3], kbdDataLineIn = lin[2], mouseClockLineIn = lin[1];
    wire         mouseDataLineIn = lin[0];
    assign {ramWr, romWr, timerIrqAck, timerOverflow, ctrlStop, ctrlHalt, ctrlEnFlags,
            ctrlPortWr, ctrlStatusWr, ctrlDataRd, ctrlDataWr} = cp;
    khp_host_port dut (.*);
    khp_isa_host host (.*);
    always #25 clock = ~clock;
    always @(posedge clock) if (wakeCall === 1'b1) wakes <= wakes + 1;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] stat(input logic [4:0] u, input logic c, ib, ob);
        return {u[4:1], c, u[0], ib, ob};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pul(input int i);
        @(posedge clock);
        cp[i] <= 1'b1;
        @(posedge clock);
        cp <= '0;
        repeat (3) @(posedge clock);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end
    initial begin
        repeat (24) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk({ctrlStatus[7:4], oe}, 8'h00);
        host.rd(HOST_STATUS_ADDR, d);
        chk(d, 8'h00);
        host.rd(16'h0061, d);
        chk(d, 8'hXX);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            cd = v[8];
            host.wr(cd ? HOST_STATUS_ADDR : HOST_DATA_ADDR, v[7:0]);
            chk(ctrlStatus, stat(ud, cd, 1'b1, 1'b0));
            chk(ctrlRdData, v[7:0]);
            if (v[9] || i == 5) begin
                pul(1);
                chk(ctrlStatus, stat(ud, cd, 1'b0, 1'b0));
            end
        end
        for (int i = 0; i < 3; i++) begin
            ctrlWrData <= 8'(rnd());
            pul(0);
            chk(ctrlStatus, stat(ud, cd, 1'b0, 1'b1));
            host.rd(HOST_DATA_ADDR, d);
            chk(d, ctrlWrData);
            chk(ctrlStatus, stat(ud, cd, 1'b0, 1'b0));
        end
        ctrlWrData <= 8'(rnd());
        pul(2);
        ud = {ctrlWrData[7:4], ctrlWrData[2]};
        host.rd(HOST_STATUS_ADDR, d);
        chk(d, stat(ud, cd, 1'b0, 1'b0));
        $display("test mailbox done");
        for (int i = 0; i < 5; i++) begin
            ctrlWrData <= 8'(rnd());
            ext <= 4'(rnd());
            pul(3);
            repeat (2) @(posedge clock);
            pv = {ctrlWrData[6], ctrlWrData[7], ctrlWrData[3:2]};
            chk({oe, sn}, {pv, ~pv & ext});
            chk({auxIrqOut, kbdIrqOut, addrLine20Gate}, {ctrlWrData[5:4], ctrlWrData[1]});
            chk(ctrlPortState, ctrlWrData);
        end
        ctrlWrData <= 8'h30;
        pul(3);
        pul(4);
        chk({kbdIrqOut, auxIrqOut}, 2'b01);
        host.wr(HOST_DATA_ADDR, 8'h5A);
        chk(auxIrqOut, 1'b0);
        pul(1);
        pul(0);
        chk({kbdIrqOut, auxIrqOut}, 2'b11);
        host.rd(HOST_DATA_ADDR, d);
        chk(kbdIrqOut, 1'b0);
        ctrlWrData <= 8'h20;
        pul(3);
        pul(0);
        chk(kbdIrqOut, 1'b0);
        host.rd(HOST_DATA_ADDR, d);
        $display("test ports done");
        ctrlIbfIntEn <= 1'b1;
        pul(5);
        chk(coreRunning, 1'b0);
        host.wr(HOST_DATA_ADDR, 8'hC3);
        chk({coreRunning, ibfIrqReq, 6'(wakes)}, 8'hC1);
        pul(1);
        ctrlIbfIntEn <= 1'b0;
        pul(6);
        chk({oscEnable, coreRunning}, 2'b00);
        host.wr(HOST_DATA_ADDR, 8'h3C);
        chk({oscEnable, coreRunning, 6'(wakes)}, 8'hC1);
        pul(1);
        pul(7);
        chk(timerIrqReq, 1'b1);
        pul(8);
        chk(timerIrqReq, 1'b0);
        // A core write while the enable is low must leave no trace
        clkEn <= 1'b0;
        pul(0);
        chk(ctrlStatus, stat(ud, 1'b0, 1'b0, 1'b0));
        clkEn <= 1'b1;
        repeat (3) @(posedge clock);
        chk(ctrlStatus, stat(ud, 1'b0, 1'b0, 1'b0));
        ctrlWrData <= 8'(rnd());
        romAddr <= 11'(rnd());
        pul(9);
        pul(10);
        chk(romRdData ^ ramRdData, 8'h00);
        chk(ramRdData, ctrlWrData);
        pul(5);
        rst_n <= 1'b0;
        repeat (24) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        chk({ctrlStatus[6:0], coreRunning}, 8'h01);
        $display("test power done");
        conclude();
    end
endmodule
`default_nettype wire

// >>> khp_checker.sv
// Concurrent checks on the keyboard controller host port
`timescale 1ns/1ps
`default_nettype none
module khp_checker (
    input wire logic       clock, rst_n, clkEn, hostRead_n, hostWrite_n, ctrlDataWr, ctrlDataRd,
    input wire logic       ctrlEnFlags, ctrlIbfIntEn, ctrlHalt, coreRunning, wakeCall, kbdIrqOut,
    input wire logic       auxIrqOut, addrLine20Gate, kbdClockLineOe, kbdDataLineOe,
    input wire logic       mouseClockLineOe, mouseDataLineOe, kbdClockLineOut, kbdDataLineOut,
    input wire logic       mouseClockLineOut, mouseDataLineOut,
    input wire logic [7:0] ctrlStatus, ctrlPortState
);
    logic flagsOn;
    logic next_flagsOn;
    // Flag mode is sticky, so a copy here needs no view of the core
    always_comb next_flagsOn = flagsOn | (ctrlEnFlags & clkEn);
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) flagsOn <= 1'b0;
        else flagsOn <= next_flagsOn;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_lines_released: assert property ({kbdClockLineOut, kbdDataLineOut,
        mouseClockLineOut, mouseDataLineOut} == 4'h0) else $error("line driven high");
    a_line_drive: assert property ($stable(ctrlPortState) |->
        {kbdClockLineOe, kbdDataLineOe, mouseClockLineOe, mouseDataLineOe} ==
        {ctrlPortState[6], ctrlPortState[7], ctrlPortState[3:2]}) else $error("line drive wrong");
    a_a20_follow: assert property ($stable(ctrlPortState) |->
        addrLine20Gate == ctrlPortState[1]) else $error("gate output wrong");
    a_aux_irq: assert property ($stable(ctrlPortState) && $stable(ctrlStatus)
        && ctrlPortState == $past(ctrlPortState, 2) && flagsOn == $past(flagsOn, 2)
        |-> $past(auxIrqOut) == (ctrlPortState[5] & !(flagsOn & ctrlStatus[1])))
        else $error("aux interrupt wrong");
    a_kbd_irq: assert property ($stable(ctrlPortState) && $stable(ctrlStatus)
        && ctrlPortState == $past(ctrlPortState, 2) && flagsOn == $past(flagsOn, 2)
        |-> $past(kbdIrqOut) == (ctrlPortState[4] & (ctrlStatus[0] | !flagsOn)))
        else $error("keyboard interrupt wrong");
    a_obf_set: assert property (ctrlDataWr && clkEn && hostRead_n && $past(hostRead_n, 3)
        |-> ##2 ctrlStatus[0]) else $error("output full not set");
    a_ibf_clear: assert property (ctrlDataRd && clkEn && hostWrite_n && $past(hostWrite_n, 3)
        |-> ##2 !ctrlStatus[1]) else $error("input full not cleared");
    a_core_halt: assert property (ctrlHalt && clkEn && hostWrite_n && $past(hostWrite_n, 3)
        |=> !coreRunning) else $error("halt ignored");
    a_wake_call: assert property ($rose(coreRunning) |->
        wakeCall == $past(ctrlIbfIntEn)) else $error("wake call wrong");
endmodule
bind khp_host_port khp_checker u_chk (.*);
`default_nettype wire

// >>> khp_host_port.sv
// Host mailbox, port glue and power-down control for the keyboard controller
`timescale 1ns/1ps
`default_nettype none
module khp_host_port
    import khp_pkg::*;
#(
    parameter int ROM_DEPTH = ROM_WORDS,
    parameter int RAM_DEPTH = RAM_WORDS
) (
    input  wire logic        clock,            // 20 MHz controller clock
    input  wire logic        rst_n,            // System reset, async low
    input  wire logic        clkEn,            // Freezes all state when low
    input  wire logic [15:0] hostAddr,         // ISA address
    input  wire logic        hostRead_n,       // ISA read strobe
    input  wire logic        hostWrite_n,      // ISA write strobe
    input  wire logic [7:0]  hostDataIn,       // ISA data in
    output logic      [7:0]  hostDataOut,      // ISA data out
    output logic             hostDataOe,       // ISA data drive enable
    input  wire logic        ctrlDataWr,       // Core writes mailbox
    input  wire logic        ctrlDataRd,       // Core reads mailbox
    input  wire logic [7:0]  ctrlWrData,       // Core write data
    output logic      [7:0]  ctrlRdData,       // Last host byte
    input  wire logic        ctrlStatusWr,     // Core writes user status bits
    output logic      [7:0]  ctrlStatus,       // Status as seen by core
    input  wire logic        ctrlPortWr,       // Core writes port two
    input  wire logic [7:0]  ctrlPortData,     // Port two write data
    output logic      [7:0]  ctrlPortState,    // Port two contents
    input  wire logic        ctrlEnFlags,      // Flag-interrupt enable executed
    input  wire logic        ctrlIbfIntEn,     // Input-full interrupt enable
    input  wire logic        ctrlHalt,         // Halt instruction
    input  wire logic        ctrlStop,         // Stop instruction
    input  wire logic        timerOverflow,    // Timer overflow pulse
    input  wire logic        timerIrqAck,      // Timer interrupt taken
    output logic             ibfIrqReq,        // Input-full interrupt to core
    output logic             timerIrqReq,      // Timer interrupt to core
    output logic             coreRunning,      // Arithmetic clock enable
    output logic             oscEnable,        // Oscillator enable
    output logic             wakeCall,         // Pulse: resume by interrupt call
    input  wire logic        romWr,            // Program ROM load strobe
    input  wire logic [10:0] romAddr,          // Program ROM address
    input  wire logic [7:0]  romWrData,        // Program ROM load data
    output logic      [7:0]  romRdData,        // Program ROM data
    input  wire logic        ramWr,            // Data RAM write
    input  wire logic [7:0]  ramAddr,          // Data RAM address
    input  wire logic [7:0]  ramWrData,        // Data RAM write data
    output logic      [7:0]  ramRdData,        // Data RAM read data
    output logic             kbdIrqOut,        // Keyboard interrupt
    output logic             auxIrqOut,        // Mouse interrupt
    output logic             addrLine20Gate,   // A20 gate output
    input  wire logic        kbdClockLineIn,   // Keyboard clock pin level
    output logic             kbdClockLineOut,  // Keyboard clock drive value
    output logic             kbdClockLineOe,   // Keyboard clock pulls low
    input  wire logic        kbdDataLineIn,    // Keyboard data pin level
    output logic             kbdDataLineOut,   // Keyboard data drive value
    output logic             kbdDataLineOe,    // Keyboard data pulls low
    input  wire logic        mouseClockLineIn, // Mouse clock pin level
    output logic             mouseClockLineOut,// Mouse clock drive value
    output logic             mouseClockLineOe, // Mouse clock pulls low
    input  wire logic        mouseDataLineIn,  // Mouse data pin level
    output logic             mouseDataLineOut, // Mouse data drive value
    output logic             mouseDataLineOe,  // Mouse data pulls low
    output logic             kbdClockSense,    // Keyboard clock test input
    output logic             kbdDataSense,     // Keyboard data port-one bit
    output logic             mouseClockSense,  // Mouse clock test input
    output logic             mouseDataSense    // Mouse data port-one bit
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_W = 2 + HOST_ADDR_W + 8 + 4;
    localparam logic [SYNC_W-1:0] SYNC_INIT = {2'b11, {(HOST_ADDR_W + 8){1'b0}}, 4'hF};

    logic [SYNC_W-1:0]      syncBus;
    logic                   rdS;
    logic                   wrS;
    logic [HOST_ADDR_W-1:0] addrS;
    logic [7:0]             dataS;

    khp_sync #(
        .WIDTH (SYNC_W),
        .INIT  (SYNC_INIT)
    ) u_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .asyncIn ({hostRead_n, hostWrite_n, hostAddr, hostDataIn,
                   kbdClockLineIn, kbdDataLineIn, mouseClockLineIn, mouseDataLineIn}),
        .syncOut (syncBus)
    );

    assign rdS             = syncBus[SYNC_W-1];
    assign wrS             = syncBus[SYNC_W-2];
    assign addrS           = syncBus[SYNC_W-3 -: HOST_ADDR_W];
    assign dataS           = syncBus[11:4];
    assign kbdClockSense   = syncBus[3];
    assign kbdDataSense    = syncBus[2];
    assign mouseClockSense = syncBus[1];
    assign mouseDataSense  = syncBus[0];

    // ****************************************
    // Host decode
    // ****************************************
    logic rdPrev;
    logic wrPrev;
    logic hitData;
    logic hitStatus;
    logic hostWrDone;
    logic hostDataRdDone;

    assign hitData        = (addrS == HOST_DATA_ADDR);
    assign hitStatus      = (addrS == HOST_STATUS_ADDR);
    // Act at the strobe's trailing edge so data and address have settled
    assign hostWrDone     = !wrPrev && wrS && (hitData || hitStatus);
    assign hostDataRdDone = !rdPrev && rdS && hitData;

    // ****************************************
    // Mailbox, status and port state
    // ****************************************
    logic       out_buf_full;
    logic       in_buf_full;
    logic       cmdFlag;
    logic [4:0] userBits;
    logic [7:0] outReg;
    logic [7:0] inReg;
    logic [7:0] portReg;
    logic       flagsOn;
    logic       timerPend;
    logic [7:0] statusVal;

    logic       next_obf;
    logic       next_ibf;
    logic       next_cmdFlag;
    logic [4:0] next_userBits;
    logic [7:0] next_outReg;
    logic [7:0] next_inReg;
    logic [7:0] next_portReg;
    logic       next_flagsOn;
    logic       next_timerPend;
    logic       next_kbdIrq;
    logic       next_auxIrq;
    logic       next_oe;
    logic [7:0] next_hostOut;

    always_comb begin
        statusVal = STATUS_RESET;
        statusVal[STAT_OBF_BIT] = out_buf_full;
        statusVal[STAT_IBF_BIT] = in_buf_full;
        statusVal[STAT_UD2_BIT] = userBits[0];
        statusVal[STAT_CD_BIT]  = cmdFlag;
        statusVal[7:STAT_UDH_LSB] = userBits[4:1];
    end

    always_comb begin
        next_outReg    = outReg;
        next_inReg     = inReg;
        next_portReg   = portReg;
        next_userBits  = userBits;
        next_cmdFlag   = cmdFlag;
        next_flagsOn   = flagsOn || ctrlEnFlags;
        next_obf       = out_buf_full;
        next_ibf       = in_buf_full;
        next_timerPend = timerPend;
        if (ctrlPortWr) begin
            next_portReg = ctrlPortData;
        end
        if (ctrlStatusWr) begin
            next_userBits = {ctrlWrData[7:STAT_UDH_LSB], ctrlWrData[STAT_UD2_BIT]};
        end
        // Clears first so a same-cycle set wins
        if (hostDataRdDone) begin
            next_obf = 1'b0;
        end
        if (ctrlDataRd) begin
            next_ibf = 1'b0;
        end
        if (ctrlDataWr) begin
            next_outReg = ctrlWrData;
            next_obf    = 1'b1;
        end
        if (hostWrDone) begin
            next_inReg   = dataS;
            next_ibf     = 1'b1;
            next_cmdFlag = addrS[HOST_CMD_BIT];
        end
        if (timerIrqAck) begin
            next_timerPend = 1'b0;
        end
        if (timerOverflow) begin
            next_timerPend = 1'b1;
        end
        // Keyboard interrupt gated by output-full, mouse interrupt by input-empty, once flags are on
        if (next_flagsOn) begin
            next_kbdIrq = next_portReg[PORT_KBD_IRQ_BIT] && next_obf;
            next_auxIrq = next_portReg[PORT_AUX_IRQ_BIT] && !next_ibf;
        end else begin
            next_kbdIrq = next_portReg[PORT_KBD_IRQ_BIT];
            next_auxIrq = next_portReg[PORT_AUX_IRQ_BIT];
        end
        next_oe      = !rdS && (hitData || hitStatus);
        next_hostOut = hitStatus ? statusVal : outReg;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdPrev          <= 1'b1;
            wrPrev          <= 1'b1;
            out_buf_full             <= 1'b0;
            in_buf_full             <= 1'b0;
            cmdFlag         <= 1'b0;
            userBits        <= 5'h00;
            portReg         <= PORT_RESET;
            flagsOn         <= 1'b0;
            timerPend       <= 1'b0;
            kbdIrqOut       <= 1'b0;
            auxIrqOut       <= 1'b0;
            hostDataOe      <= 1'b0;
            hostDataOut     <= 8'h00;
            ctrlStatus      <= STATUS_RESET;
            ctrlPortState   <= PORT_RESET;
            addrLine20Gate  <= 1'b0;
            kbdClockLineOe  <= 1'b0;
            kbdDataLineOe   <= 1'b0;
            mouseClockLineOe <= 1'b0;
            mouseDataLineOe <= 1'b0;
            ibfIrqReq       <= 1'b0;
            timerIrqReq     <= 1'b0;
        end else if (clkEn) begin
            rdPrev          <= rdS;
            wrPrev          <= wrS;
            out_buf_full             <= next_obf;
            in_buf_full             <= next_ibf;
            cmdFlag         <= next_cmdFlag;
            userBits        <= next_userBits;
            portReg         <= next_portReg;
            flagsOn         <= next_flagsOn;
            timerPend       <= next_timerPend;
            kbdIrqOut       <= next_kbdIrq;
            auxIrqOut       <= next_auxIrq;
            hostDataOe      <= next_oe;
            hostDataOut     <= next_hostOut;
            ctrlStatus      <= statusVal;
            ctrlPortState   <= next_portReg;
            addrLine20Gate  <= next_portReg[PORT_A20_BIT];
            // A one in the port bit pulls the pin low
            kbdClockLineOe  <= next_portReg[PORT_KBD_CLK_BIT];
            kbdDataLineOe   <= next_portReg[PORT_KBD_DAT_BIT];
            mouseClockLineOe <= next_portReg[PORT_MOUSE_CLK_BIT];
            mouseDataLineOe <= next_portReg[PORT_MOUSE_DAT_BIT];
            ibfIrqReq       <= next_ibf && ctrlIbfIntEn;
            timerIrqReq     <= next_timerPend;
        end
    end

    // Open drain: the only value ever driven is low
    assign kbdClockLineOut   = 1'b0;
    assign kbdDataLineOut    = 1'b0;
    assign mouseClockLineOut = 1'b0;
    assign mouseDataLineOut  = 1'b0;

    // Data buffers have no defined reset value
    always_ff @(posedge clock) begin
        if (clkEn) begin
            outReg     <= next_outReg;
            inReg      <= next_inReg;
            ctrlRdData <= next_inReg;
        end
    end

    // ****************************************
    // Power-down control
    // ****************************************
    khp_power_e powerState;
    khp_power_e next_powerState;
    logic       next_wakeCall;

    always_comb begin
        next_powerState = powerState;
        next_wakeCall   = 1'b0;
        unique case (powerState)
            KHP_RUN: begin
                if (ctrlStop) begin
                    next_powerState = KHP_HARD;
                end else if (ctrlHalt) begin
                    next_powerState = KHP_SOFT;
                end
            end
            KHP_SOFT, KHP_HARD: begin
                // Only a host write wakes; reset wakes through rst_n
                if (hostWrDone) begin
                    next_powerState = KHP_RUN;
                    next_wakeCall   = ctrlIbfIntEn;
                end
            end
            default: begin
                next_powerState = KHP_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Reset restarts the core from address zero in run state
            powerState  <= KHP_RUN;
            coreRunning <= 1'b1;
            oscEnable   <= 1'b1;
            wakeCall    <= 1'b0;
        end else if (clkEn) begin
            powerState  <= next_powerState;
            coreRunning <= (next_powerState == KHP_RUN);
            oscEnable   <= (next_powerState != KHP_HARD);
            wakeCall    <= next_wakeCall;
        end
    end

    // ****************************************
    // Program ROM and data RAM
    // ****************************************
    // ROM is loaded through a write port; a mask ROM would fix its contents
    logic [7:0] romMem [ROM_DEPTH];
    logic [7:0] ramMem [RAM_DEPTH];

    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (romWr) begin
                romMem[romAddr] <= romWrData;
            end
            if (ramWr) begin
                ramMem[ramAddr] <= ramWrData;
            end
            romRdData <= romMem[romAddr];
            ramRdData <= ramMem[ramAddr];
        end
    end

endmodule
`default_nettype wire

// >>> khp_isa_host.sv
// Behavioural ISA host that reads and writes the keyboard mailbox
`timescale 1ns/1ps
`default_nettype none
module khp_isa_host (
    input  wire logic        clock,       // Bus clock
    input  wire logic [7:0]  hostDataOut, // Data from device
    input  wire logic        hostDataOe,  // Device drives data
    output logic      [15:0] hostAddr = 16'hFFFF, // Address
    output logic             hostRead_n = 1'b1,   // Read strobe
    output logic             hostWrite_n = 1'b1,  // Write strobe
    output logic      [7:0]  hostDataIn = 8'h00   // Write data
);
    // Strobes span several clocks so the synchronisers cannot miss them
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        hostAddr <= a;
        hostDataIn <= d;
        hostWrite_n <= 1'b0;
        repeat (4) @(posedge clock);
        hostWrite_n <= 1'b1;
        repeat (6) @(posedge clock);
        hostAddr <= ~a;
        hostDataIn <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        hostAddr <= a;
        hostRead_n <= 1'b0;
        repeat (5) @(posedge clock);
        d = hostDataOe ? hostDataOut : 8'hXX;
        hostRead_n <= 1'b1;
        repeat (6) @(posedge clock);
        hostAddr <= ~a;
    endtask
endmodule
`default_nettype wire

// >>> khp_pkg.sv
// Shared constants for the keyboard controller host port
package khp_pkg;

    // ****************************************
    // Host I/O decode
    // ****************************************
    localparam logic [15:0] HOST_DATA_ADDR   = 16'h0060;
    localparam logic [15:0] HOST_STATUS_ADDR = 16'h0064;
    localparam int          HOST_ADDR_W      = 16;
    localparam int          HOST_CMD_BIT     = 2;

    // ****************************************
    // Status register layout
    // ****************************************
    localparam int         STAT_OBF_BIT = 0;
    localparam int         STAT_IBF_BIT = 1;
    localparam int         STAT_UD2_BIT = 2;
    localparam int         STAT_CD_BIT  = 3;
    localparam int         STAT_UDH_LSB = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ****************************************
    // Port-two bit positions and reset value
    // ****************************************
    localparam int         PORT_A20_BIT       = 1;
    localparam int         PORT_MOUSE_DAT_BIT = 2;
    localparam int         PORT_MOUSE_CLK_BIT = 3;
    localparam int         PORT_KBD_IRQ_BIT   = 4;
    localparam int         PORT_AUX_IRQ_BIT   = 5;
    localparam int         PORT_KBD_CLK_BIT   = 6;
    localparam int         PORT_KBD_DAT_BIT   = 7;
    localparam logic [7:0] PORT_RESET         = 8'h00;

    // ****************************************
    // Memory sizes and reset timing
    // ****************************************
    localparam int ROM_WORDS         = 2048;
    localparam int RAM_WORDS         = 256;
    localparam int RESET_MIN_CYCLES  = 24;

    // ****************************************
    // Power states
    // ****************************************
    typedef enum logic [2:0] {
        KHP_RUN  = 3'b001,
        KHP_SOFT = 3'b010,
        KHP_HARD = 3'b100
    } khp_power_e;

endpackage

// >>> khp_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module khp_sync #(
    parameter int             WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clock,    // Controller clock
    input  wire logic             rst_n,    // Async reset
    input  wire logic             clkEn,    // Clock enable
    input  wire logic [WIDTH-1:0] asyncIn,  // Raw input
    output logic      [WIDTH-1:0] syncOut   // Synchronised output
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1  <= INIT;
            syncOut <= INIT;
        end else if (clkEn) begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule
`default_nettype wire
